// file: src/usbpa_defs.svh
// constants for the usb port accessory switch pin block
`ifndef USBPA_DEFS_SVH
`define USBPA_DEFS_SVH

`define USBPA_CLK_HZ        25000000
`define USBPA_STUCK_MS      30
`define USBPA_STUCK_CYCLES  (`USBPA_STUCK_MS * (`USBPA_CLK_HZ / 1000))
`define USBPA_I2C_MAX_KHZ   400
`define USBPA_I2C_MIN_OVS   8
`define USBPA_I2C_ADDR      7'h25
`define USBPA_ID_OPEN_CODE  5'h1F
`define USBPA_ID_W          5
`define USBPA_N_DEST        3
`define USBPA_DEST_HOST     0
`define USBPA_DEST_AUDIO    1
`define USBPA_DEST_UART     2
`define USBPA_RST_IRQ_N     1'b1
`define USBPA_RST_PP_OUT    1'b0

`endif

// file: src/usbpa_pkg.sv
// types shared by the usb port accessory switch pin block
package usbpa_pkg;

    // signaling mode requested on the sig_mode pins
    typedef enum logic [1:0] {
        USBPA_MODE_OPEN,
        USBPA_MODE_USB,
        USBPA_MODE_AUDIO,
        USBPA_MODE_UART
    } usbpa_mode_e;

    // two-wire slave states
    typedef enum logic [2:0] {
        USBPA_I2C_IDLE,
        USBPA_I2C_ADDR,
        USBPA_I2C_AACK,
        USBPA_I2C_TX,
        USBPA_I2C_MACK,
        USBPA_I2C_WR,
        USBPA_I2C_WACK
    } usbpa_i2c_e;

    // whole state of the top module
    typedef struct packed {
        usbpa_i2c_e  st;          // slave state
        logic [3:0]  bitcnt;      // bits seen in current byte
        logic [7:0]  sr;          // shift register
        logic        rw;          // read when set
        logic        mack;        // master acked last byte
        logic        sda_oe;      // pull sda low
        logic        scl_q;       // previous scl sample
        logic        sda_q;       // previous sda sample
        logic [4:0]  id_prev;     // last id line code
        logic        attach_prev; // last attach status
        logic        button;      // sticky button press
        logic        irq_n;       // interrupt pin
        logic        chg_oe;      // charger pin pulled low
        logic        fod_oe;      // factory od pin pulled low
        logic        pp_out;      // factory push-pull pin
        logic [19:0] stuck_cnt;   // both-lines-low counter
        logic        stuck_fired; // reset already given
        logic        bus_rst;     // one-cycle internal reset
    } usbpa_state_s;

endpackage

// file: src/usbpa_route_if.sv
// route request and switch enables between top and one path selector
`timescale 1ns/1ps
interface usbpa_route_if;
    import usbpa_pkg::*;
    usbpa_mode_e mode; // requested signaling mode
    logic [2:0]  en;   // one-hot destination enables
    modport ctl (output mode, input en);
    modport sw  (input mode, output en);
endinterface

// file: src/usbpa_path_sel.sv
// one connector data line to one of three destinations
`timescale 1ns/1ps
`include "usbpa_defs.svh"
module usbpa_path_sel
    import usbpa_pkg::*;
#(
    parameter int N_DEST = `USBPA_N_DEST
)(
    input  wire logic   clk,
    input  wire logic   rst,
    usbpa_route_if.sw   rt
);
    // the mode decode below only knows three destinations
    if (N_DEST != 3) begin : g_chk
        $error("usbpa_path_sel serves exactly three destinations");
    end

    logic [2:0] en;      // registered enables
    logic [2:0] next_en; // decoded enables

    // decode mode into at most one closed path
    always_comb
    begin
        next_en = 3'h0;
        case (rt.mode)
            USBPA_MODE_USB:   next_en[`USBPA_DEST_HOST]  = 1'b1;
            USBPA_MODE_AUDIO: next_en[`USBPA_DEST_AUDIO] = 1'b1;
            USBPA_MODE_UART:  next_en[`USBPA_DEST_UART]  = 1'b1;
            default:          next_en = 3'h0;                    // open
        endcase
    end

    // break before make is not modelled; a mode change swaps in one edge
    always_ff @(posedge clk)
    begin
        if (rst)
            en <= 3'h0;
        else
            en <= next_en;
    end

    assign rt.en = en;

    AST_PATH_ONEHOT: assert property (@(posedge clk) disable iff (rst) $onehot0(en))
        else $error("more than one path closed");

    AST_PATH_OPEN_RST: assert property (@(posedge clk) rst |=> en == 3'h0)
        else $error("path not open after reset");

    AST_PATH_USB: assert property (@(posedge clk) disable iff (rst)
        rt.mode == USBPA_MODE_USB ##1 !rst |-> en == 3'h1)
        else $error("usb mode did not close host path");

    AST_PATH_UART: assert property (@(posedge clk) disable iff (rst)
        rt.mode == USBPA_MODE_UART ##1 !rst |-> en == 3'h4)
        else $error("uart mode did not close serial path");
endmodule

// file: src/usbpa_switch_pins.sv
// pin-level control of the usb port accessory switch
//
// How it works
// - plus line goes to one destination.
// - minus line goes to one destination.
// - charger attached pulls charger pin low.
// - active-low interrupt prompts status read.
// - id or attach change raises interrupt.
// - id line identifies accessories and buttons.
// - factory outputs: open-drain off, push-pull low after reset.
// - reset opens paths, restores defaults.
// - two-wire slave up to 400 kHz.
// - both bus lines low 30ms resets.
`timescale 1ns/1ps
`include "usbpa_defs.svh"
module usbpa_switch_pins
    import usbpa_pkg::*;
#(
    parameter int STUCK_CYCLES = `USBPA_STUCK_CYCLES,
    parameter logic [6:0] SLAVE_ADDR = `USBPA_I2C_ADDR
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] sig_mode,          // requested mode code
    input  wire logic [4:0] connector_id_line, // digitised id level
    input  wire logic       accessory_attached,
    input  wire logic       charger_attached,
    input  wire logic       factory_od_req,
    input  wire logic       factory_pp_req,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            host_irq_n,
    output logic            charger_attach_n_oe,
    output logic            factory_test_od_out_oe,
    output logic            factory_test_pp_out,
    output logic            plus_to_host_plus_line,
    output logic            plus_to_audio_right,
    output logic            plus_to_uart_rx,
    output logic            minus_to_host_minus_line,
    output logic            minus_to_audio_left,
    output logic            minus_to_uart_tx
);
    // counter and sampling limits the logic can serve
    if (STUCK_CYCLES < 2 || STUCK_CYCLES > 1048575) begin : g_chk_stuck
        $error("STUCK_CYCLES out of counter range");
    end
    if (`USBPA_CLK_HZ / (`USBPA_I2C_MAX_KHZ * 1000) < `USBPA_I2C_MIN_OVS) begin : g_chk_ovs
        $error("clock too slow to sample the serial bus");
    end
    localparam logic [19:0] STUCK_LAST = 20'(STUCK_CYCLES - 1);
    localparam usbpa_state_s RESET_STATE = '{
        st: USBPA_I2C_IDLE, bitcnt: 4'h0, sr: 8'h00, rw: 1'b0, mack: 1'b0,
        sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1, id_prev: `USBPA_ID_OPEN_CODE,
        attach_prev: 1'b0, button: 1'b0, irq_n: `USBPA_RST_IRQ_N, chg_oe: 1'b0,
        fod_oe: 1'b0, pp_out: `USBPA_RST_PP_OUT, stuck_cnt: 20'h00000,
        stuck_fired: 1'b0, bus_rst: 1'b0};
    usbpa_state_s s;      // registered state
    usbpa_state_s next_s; // next state
    logic       scl_rise, scl_fall; // bus clock edges
    logic       start_c, stop_c;    // start or repeated start, stop
    logic       id_chg, att_chg;    // id code or attach status moved
    logic       evt;                // interrupt event this cycle
    logic       rd_clear;           // status byte handed out
    logic [7:0] status;             // status byte served on reads
    logic       route_rst;          // pin reset or bus-stuck reset
    // bus line edges and conditions from previous samples
    assign scl_rise = scl_in && !s.scl_q;
    assign scl_fall = !scl_in && s.scl_q;
    assign start_c  = scl_in && s.scl_q && s.sda_q && !sda_in;
    assign stop_c   = scl_in && s.scl_q && !s.sda_q && sda_in;
    // accessory events; a button is an id move while attach stays
    assign id_chg  = connector_id_line != s.id_prev;
    assign att_chg = accessory_attached != s.attach_prev;
    assign evt     = id_chg || att_chg;
    assign status  = {s.attach_prev, s.button, s.id_prev, charger_attached};
    assign rd_clear = s.st == USBPA_I2C_AACK && scl_fall && s.rw;

    // next state
    always_comb
    begin
        next_s = s;
        next_s.scl_q   = scl_in;
        next_s.sda_q   = sda_in;
        next_s.bus_rst = 1'b0;
        next_s.id_prev = connector_id_line;
        next_s.attach_prev = accessory_attached;
        // sticky button flag, set wins over the read clear
        if (rd_clear)
            next_s.button = 1'b0;
        if (s.attach_prev && accessory_attached && id_chg)
            next_s.button = 1'b1;
        // interrupt: read of status releases it, a new event wins
        if (rd_clear)
            next_s.irq_n = 1'b1;
        if (evt)
            next_s.irq_n = 1'b0;
        // open-drain and push-pull side pins
        next_s.chg_oe = charger_attached;
        next_s.fod_oe = factory_od_req;
        next_s.pp_out = factory_pp_req;
        // both lines low too long forces an internal reset once
        if (!scl_in && !sda_in)
        begin
            if (s.stuck_cnt == STUCK_LAST && !s.stuck_fired)
            begin
                next_s.bus_rst     = 1'b1;
                next_s.stuck_fired = 1'b1;
            end
            else if (s.stuck_cnt != STUCK_LAST)
                next_s.stuck_cnt = 20'(s.stuck_cnt + 20'h00001);
        end
        else
        begin
            next_s.stuck_cnt   = 20'h00000;
            next_s.stuck_fired = 1'b0;
        end
        // two-wire slave; written bytes are acked but not stored
        case (s.st)
            USBPA_I2C_IDLE: ;
            USBPA_I2C_ADDR:
            begin
                if (scl_rise)
                begin
                    next_s.sr     = {s.sr[6:0], sda_in};
                    next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                end
                else if (scl_fall && s.bitcnt == 4'h8)
                begin
                    if (s.sr[7:1] == SLAVE_ADDR)
                    begin
                        next_s.sda_oe = 1'b1;
                        next_s.rw     = s.sr[0];
                        next_s.st     = USBPA_I2C_AACK;
                    end
                    else
                        next_s.st = USBPA_I2C_IDLE; // not ours
                end
            end
            USBPA_I2C_AACK:
            begin
                if (scl_fall)
                begin
                    next_s.bitcnt = 4'h0;
                    if (s.rw)
                    begin
                        next_s.sr     = status;
                        next_s.sda_oe = !status[7];
                        next_s.st     = USBPA_I2C_TX;
                    end
                    else
                    begin
                        next_s.sda_oe = 1'b0;
                        next_s.st     = USBPA_I2C_WR;
                    end
                end
            end
            USBPA_I2C_TX:
            begin
                if (scl_rise)
                    next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                else if (scl_fall && s.bitcnt == 4'h8)
                begin
                    next_s.sda_oe = 1'b0; // master drives the ack
                    next_s.st     = USBPA_I2C_MACK;
                end
                else if (scl_fall)
                begin
                    next_s.sr     = {s.sr[6:0], 1'b0};
                    next_s.sda_oe = !s.sr[6];
                end
            end
            USBPA_I2C_MACK:
            begin
                if (scl_rise)
                    next_s.mack = !sda_in;
                else if (scl_fall && s.mack)
                begin
                    // repeated status byte while the master keeps acking
                    next_s.sr     = status;
                    next_s.sda_oe = !status[7];
                    next_s.bitcnt = 4'h0;
                    next_s.st     = USBPA_I2C_TX;
                end
                else if (scl_fall)
                    next_s.st = USBPA_I2C_IDLE;
            end
            USBPA_I2C_WR:
            begin
                if (scl_rise)
                    next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                else if (scl_fall && s.bitcnt == 4'h8)
                begin
                    next_s.sda_oe = 1'b1;
                    next_s.st     = USBPA_I2C_WACK;
                end
            end
            USBPA_I2C_WACK:
            begin
                if (scl_fall)
                begin
                    next_s.sda_oe = 1'b0;
                    next_s.bitcnt = 4'h0;
                    next_s.st     = USBPA_I2C_WR;
                end
            end
            default: next_s.st = USBPA_I2C_IDLE;
        endcase
        // start and stop override any byte in flight
        if (start_c)
        begin
            next_s.st     = USBPA_I2C_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            next_s.st     = USBPA_I2C_IDLE;
            next_s.sda_oe = 1'b0;
        end
        // internal reset restores defaults but keeps the stuck counter
        if (s.bus_rst)
        begin
            next_s = RESET_STATE;
            next_s.stuck_cnt   = s.stuck_cnt;
            next_s.stuck_fired = s.stuck_fired;
        end
    end

    // single state register
    always_ff @(posedge clk)
    begin
        if (rst)
            s <= RESET_STATE;
        else
            s <= next_s;
    end
    assign route_rst = rst || s.bus_rst;
    usbpa_route_if rt_plus ();  // plus line path
    usbpa_route_if rt_minus (); // minus line path
    assign rt_plus.mode  = usbpa_mode_e'(sig_mode);
    assign rt_minus.mode = usbpa_mode_e'(sig_mode);
    usbpa_path_sel #(.N_DEST(`USBPA_N_DEST)) u_plus (
        .clk (clk), .rst (route_rst), .rt (rt_plus));
    usbpa_path_sel #(.N_DEST(`USBPA_N_DEST)) u_minus (
        .clk (clk), .rst (route_rst), .rt (rt_minus));
    // pin outputs straight from the state flops, switch outputs from the path selector enable flops
    assign sda_out                  = 1'b0; // open-drain level
    assign sda_oe                   = s.sda_oe;
    assign host_irq_n               = s.irq_n;
    assign charger_attach_n_oe      = s.chg_oe;
    assign factory_test_od_out_oe   = s.fod_oe;
    assign factory_test_pp_out      = s.pp_out;
    assign plus_to_host_plus_line   = rt_plus.en[`USBPA_DEST_HOST];
    assign plus_to_audio_right      = rt_plus.en[`USBPA_DEST_AUDIO];
    assign plus_to_uart_rx          = rt_plus.en[`USBPA_DEST_UART];
    assign minus_to_host_minus_line = rt_minus.en[`USBPA_DEST_HOST];
    assign minus_to_audio_left      = rt_minus.en[`USBPA_DEST_AUDIO];
    assign minus_to_uart_tx         = rt_minus.en[`USBPA_DEST_UART];
    sequence seq_release;
        rst ##1 !rst;
    endsequence
    sequence seq_stuck_end;
        !scl_in && !sda_in && s.stuck_cnt == STUCK_LAST && !s.stuck_fired;
    endsequence
    AST_IRQ_ON_EVENT: assert property (@(posedge clk) disable iff (rst)
        evt && !s.bus_rst |=> !host_irq_n)
        else $error("event did not raise interrupt");
    AST_IRQ_READ_CLEAR: assert property (@(posedge clk) disable iff (rst)
        rd_clear && !evt && !s.bus_rst |=> host_irq_n)
        else $error("status read did not release interrupt");
    AST_CHG_PIN: assert property (@(posedge clk) disable iff (rst)
        !s.bus_rst |=> charger_attach_n_oe == $past(charger_attached))
        else $error("charger pin does not follow attach");
    AST_DEFAULTS: assert property (@(posedge clk)
        seq_release |-> host_irq_n && !factory_test_pp_out
        && !factory_test_od_out_oe && !charger_attach_n_oe && !sda_oe)
        else $error("outputs not at default after reset");
    AST_FACTORY_PP: assert property (@(posedge clk) disable iff (rst)
        factory_pp_req && !s.bus_rst ##1 1'b1 |-> factory_test_pp_out)
        else $error("factory push-pull pin not driven");
    AST_STUCK_RESET: assert property (@(posedge clk) disable iff (rst)
        seq_stuck_end |=> s.bus_rst ##1 !plus_to_host_plus_line
        && !minus_to_host_minus_line)
        else $error("stuck bus did not reset");
    AST_ADDR_ACK: assert property (@(posedge clk) disable iff (rst)
        s.st == USBPA_I2C_ADDR && scl_fall && s.bitcnt == 4'h8
        && s.sr[7:1] == SLAVE_ADDR && !start_c && !stop_c && !s.bus_rst
        |=> sda_oe && s.st == USBPA_I2C_AACK)
        else $error("own address not acked");
    AST_BUTTON: assert property (@(posedge clk) disable iff (rst)
        s.attach_prev && accessory_attached && id_chg && !s.bus_rst
        |=> s.button && !host_irq_n)
        else $error("button press not flagged");
endmodule

// file: tb/usbpa_i2c_master.sv
// two-wire bus master standing in for the baseband processor
`timescale 1ns/1ps
module usbpa_i2c_master #(
    parameter int QTR = 16 // quarter bit; 64 clocks a bit stays under 400 kHz
)(
    input  wire logic clk,
    input  wire logic sda,     // resolved bus data
    output logic      scl,     // bus clock, idles high
    output logic      sda_pull // high pulls data low
);
    // bus idle: both lines released
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // a quarter of a bit time
    task automatic qwait();
        repeat (QTR) @(posedge clk);
    endtask
    // start: data falls while clock high
    task automatic start();
        @(posedge clk);
        sda_pull <= 1'b1;
        qwait();
        scl <= 1'b0;
        qwait();
    endtask
    // stop: data rises while clock high
    task automatic stop();
        sda_pull <= 1'b1;
        qwait();
        scl <= 1'b1;
        qwait();
        sda_pull <= 1'b0;
        qwait();
    endtask
    // data moves only while clock low, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic s);
        sda_pull <= ~b;
        qwait();
        scl <= 1'b1;
        qwait();
        s = sda;
        qwait();
        scl <= 1'b0;
        qwait();
    endtask
    // eight bits then the ack slot; a 1 sent releases the line
    task automatic byte_xfer(input logic [7:0] d, input logic ack_out,
                             output logic [7:0] r, output logic ack_in);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(d[i], b);
            r[i] = b;
        end
        bit_xfer(ack_out, ack_in);
    endtask
    // both lines low for n clocks; short holds must not reset
    task automatic hold_low(input int n);
        @(posedge clk);
        sda_pull <= 1'b1;
        qwait();
        scl <= 1'b0;
        repeat (n) @(posedge clk);
        scl <= 1'b1;
        qwait();
        sda_pull <= 1'b0;
        qwait();
        // hand back off the edge so the caller samples settled outputs
        @(negedge clk);
    endtask
endmodule

// file: tb/usbpa_switch_pins_test.sv
// self-checking bench for the usb port accessory switch pins
`timescale 1ns/1ps
`include "usbpa_defs.svh"
module usbpa_switch_pins_test;
    import usbpa_pkg::*;
    localparam int         STUCK = 50;               // short stand-in for 30 ms
    localparam logic [6:0] ADDR  = `USBPA_I2C_ADDR;  // slave address
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] sig_mode = 2'h1;                // nonzero so reset must win
    logic [4:0] connector_id_line = 5'h1F;      // nothing on id
    logic       accessory_attached = 1'b0;
    logic       charger_attached = 1'b1;
    logic       factory_od_req = 1'b1;
    logic       factory_pp_req = 1'b1;
    logic       scl, sda_pull, sda, sda_out, sda_oe, host_irq_n;
    logic       charger_attach_n_oe, factory_test_od_out_oe, factory_test_pp_out;
    logic       p_host, p_aud, p_uart, m_host, m_aud, m_uart;
    logic [5:0] route;                           // plus then minus switches
    logic [2:0] side;                            // charger, factory od, factory pp
    int         fails = 0;
    int         n_checks = 0;
    // open-drain wire with pull-up: low if either party pulls
    assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
    assign route = {p_host, p_aud, p_uart, m_host, m_aud, m_uart};
    assign side = {charger_attach_n_oe, factory_test_od_out_oe, factory_test_pp_out};
    // 25 MHz clock
    always #20 clk = ~clk;
    usbpa_switch_pins #(.STUCK_CYCLES(STUCK), .SLAVE_ADDR(ADDR)) dut_u (
        .clk(clk), .rst(rst), .sig_mode(sig_mode),
        .connector_id_line(connector_id_line), .accessory_attached(accessory_attached),
        .charger_attached(charger_attached), .factory_od_req(factory_od_req),
        .factory_pp_req(factory_pp_req), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .host_irq_n(host_irq_n),
        .charger_attach_n_oe(charger_attach_n_oe),
        .factory_test_od_out_oe(factory_test_od_out_oe),
        .factory_test_pp_out(factory_test_pp_out),
        .plus_to_host_plus_line(p_host), .plus_to_audio_right(p_aud),
        .plus_to_uart_rx(p_uart), .minus_to_host_minus_line(m_host),
        .minus_to_audio_left(m_aud), .minus_to_uart_tx(m_uart));
    usbpa_i2c_master master_u (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    // expected switch set: exactly one path per line, none when open
    function automatic logic [5:0] exp_route(input logic [1:0] m);
        case (m)
            2'h1: return 6'h24;
            2'h2: return 6'h12;
            2'h3: return 6'h09;
            default: return 6'h00;
        endcase
    endfunction
    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // status change: irq must fall exactly one edge after it is taken
    task automatic raise(input logic [4:0] id, input logic att);
        @(posedge clk);
        connector_id_line <= id;
        accessory_attached <= att;
        @(negedge clk);
        check("irq before", 8'(host_irq_n), 8'h01);
        @(negedge clk);
        check("irq after", 8'(host_irq_n), 8'h00);
    endtask
    // read one status byte; a foreign address must be left unanswered
    task automatic read_status(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] r;
        logic       a;
        master_u.start();
        master_u.byte_xfer({addr, 1'b1}, 1'b1, r, a);
        check("addr ack", 8'(a), 8'(addr != ADDR));
        if (a === 1'b0)
        begin
            master_u.byte_xfer(8'hFF, 1'b1, r, a);
            check("status", r, exp);
        end
        master_u.stop();
        @(negedge clk);
    endtask
    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        logic [1:0] m, pm;
        logic [2:0] s, ps;
        logic [4:0] ida, idb;
        logic [7:0] r;
        logic       a;
        void'($urandom(32'h7086));
        repeat (10) @(posedge clk);
        @(negedge clk);
        // defaults while reset held despite active requests
        check("reset route", 8'(route), 8'h00);
        check("reset side", 8'(side), 8'h00);
        check("reset irq", 8'(host_irq_n), 8'h01);
        check("reset sda", 8'(sda_oe), 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        // back-to-back mode and side pin changes, all modes first
        for (int i = 0; i < 300; i++)
        begin
            @(posedge clk);
            m = (i < 4) ? 2'(i) : 2'($urandom);
            s = 3'($urandom);
            sig_mode <= m;
            {charger_attached, factory_od_req, factory_pp_req} <= s;
            @(negedge clk);
            if (i > 0)
            begin
                check("route", 8'(route), 8'(exp_route(pm)));
                check("side", 8'(side), 8'(ps));
            end
            pm = m;
            ps = s;
        end
        // attach with id code: irq stands until status read
        ida = 5'($urandom_range(30));
        idb = ida ^ 5'h01;
        raise(ida, 1'b1);
        repeat (20) @(posedge clk);
        check("irq stands", 8'(host_irq_n), 8'h00);
        read_status(ADDR, {1'b1, 1'b0, ida, ps[2]});
        check("irq cleared", 8'(host_irq_n), 8'h01);
        // id change while attached is a button press, cleared by the read
        raise(idb, 1'b1);
        read_status(ADDR, {1'b1, 1'b1, idb, ps[2]});
        read_status(ADDR, {1'b1, 1'b0, idb, ps[2]});
        check("irq quiet", 8'(host_irq_n), 8'h01);
        // detach alone raises irq; foreign address must not clear it
        raise(idb, 1'b0);
        read_status(ADDR ^ 7'h01, 8'h00);
        check("irq kept", 8'(host_irq_n), 8'h00);
        read_status(ADDR, {1'b0, 1'b0, idb, ps[2]});
        // write: address and data both acked
        master_u.start();
        master_u.byte_xfer({ADDR, 1'b0}, 1'b1, r, a);
        check("wr addr ack", 8'(a), 8'h00);
        master_u.byte_xfer(8'($urandom), 1'b1, r, a);
        check("wr data ack", 8'(a), 8'h00);
        master_u.stop();
        // bus held low: short hold keeps state, long hold resets
        raise(5'h1F, 1'b0);
        master_u.hold_low(STUCK - 10);
        check("short hold", 8'(host_irq_n), 8'h00);
        master_u.hold_low(STUCK + 6);
        check("long hold irq", 8'(host_irq_n), 8'h01);
        check("long hold sda", 8'(sda_oe), 8'h00);
        give_verdict();
    end
endmodule
